// ---- design/pfs_defines.vh ----
// constants for the program flash erase/write sequencer
// assumes a single system clock domain at 125 MHz
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH
// --------------------------------------------------------------
// control register fields
// --------------------------------------------------------------
`define PFS_OP_LSB        0
`define PFS_OP_MSB        3
`define PFS_ERASE_BIT     6
`define PFS_FLASH_WRITE_ENABLE_BIT_BIT      14
`define PFS_START_BIT     15
`define PFS_CTRL_RST      16'h0000
`define PFS_OP_ROW_PROG   4'h1
`define PFS_OP_PAGE_ERASE 4'h2
// --------------------------------------------------------------
// unlock keys
// --------------------------------------------------------------
`define PFS_KEY1          8'h55
`define PFS_KEY2          8'haa
// --------------------------------------------------------------
// array geometry and timing
// --------------------------------------------------------------
`define PFS_ROW_WORDS     64
`define PFS_PAGE_ROWS     8
`define PFS_ROW_BITS      6
`define PFS_PAGE_BITS     9
`define PFS_CLK_MHZ       125
`define PFS_ERASE_US      20
`define PFS_PROG_US       2
`define PFS_ERASE_CYC     (`PFS_ERASE_US * `PFS_CLK_MHZ)
`define PFS_PROG_CYC      (`PFS_PROG_US * `PFS_CLK_MHZ)
`endif

// ---- design/pfs_sequencer.v ----
// flash erase / row program sequencer with key unlock and cpu stall
// assumes all inputs come from logic on clk_sys_i; flash array is outside
`include "pfs_defines.vh"

module pfs_sequencer #(
  parameter ERASE_CYC = `PFS_ERASE_CYC,
  parameter PROG_CYC  = `PFS_PROG_CYC,
  parameter AW        = 24,
  parameter DW        = 24
) (
  // clock and reset
  input  wire          clk_sys_i,
  input  wire          nrst_i,
  // register writes
  input  wire          ctrl_wr_i,
  input  wire [15:0]   ctrl_wdata_i,
  input  wire          key_wr_i,
  input  wire [7:0]    key_wdata_i,
  input  wire          page_wr_i,
  input  wire [7:0]    page_wdata_i,
  // table write low word
  input  wire          tbl_wr_i,
  input  wire [15:0]   tbl_addr_i,
  input  wire [DW-1:0] tbl_data_i,
  // status
  output reg  [15:0]   ctrl_o,
  output reg           cpu_stall_o,
  output reg           unlocked_o,
  // flash array side
  output reg           fl_erase_o,
  output reg           fl_prog_o,
  output reg  [AW-1:0] fl_addr_o,
  output reg  [DW-1:0] fl_data_o
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_ERASE = 3'b010;
  localparam ST_PROG  = 3'b100;
  localparam CW       = 20;

  reg [2:0]    state_ff;
  reg [15:0]   ctrl_ff;
  reg [7:0]    page_ff;
  reg          key1_ff;
  reg          unlk_ff;
  reg [AW-1:0] tgt_ff;
  reg [CW-1:0] cnt_ff;
  // one spare bit: the top bit marks the row as fully streamed
  reg [`PFS_ROW_BITS:0]   idx_ff;
  reg [DW-1:0] rowbuf [0:`PFS_ROW_WORDS-1];

  wire [3:0] op_w   = ctrl_ff[`PFS_OP_MSB:`PFS_OP_LSB];
  wire [3:0] nop_w  = ctrl_wdata_i[`PFS_OP_MSB:`PFS_OP_LSB];
  wire start_w = ctrl_wr_i && ctrl_wdata_i[`PFS_START_BIT]
                 && (state_ff == ST_IDLE);
  wire go_w    = start_w && unlk_ff && ctrl_wdata_i[`PFS_FLASH_WRITE_ENABLE_BIT_BIT];
  wire ers_w   = (nop_w == `PFS_OP_PAGE_ERASE)
                 && ctrl_wdata_i[`PFS_ERASE_BIT];
  wire prg_w   = (nop_w == `PFS_OP_ROW_PROG)
                 && !ctrl_wdata_i[`PFS_ERASE_BIT];
  wire any_wr  = ctrl_wr_i | page_wr_i | tbl_wr_i | key_wr_i;
  wire [`PFS_ROW_BITS-1:0] word_w = idx_ff[`PFS_ROW_BITS-1:0];

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // true on the last cycle of a timed erase or program
  function last_cyc;
    input [CW-1:0] c;
    begin
      last_cyc = (c == {{(CW-1){1'b0}}, 1'b1});
    end
  endfunction

  // --------------------------------------------------------------
  // row buffer, written by table writes while idle
  // --------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (tbl_wr_i && state_ff == ST_IDLE) begin
      rowbuf[tbl_addr_i[`PFS_ROW_BITS-1:0]] <= tbl_data_i;
    end
  end

  // --------------------------------------------------------------
  // unlock keys
  // --------------------------------------------------------------
  // 0x55 then 0xaa as back-to-back writes; any other write, a control
  // write included, spends the unlock so each operation needs its own
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      key1_ff    <= 1'b0;
      unlk_ff    <= 1'b0;
      unlocked_o <= 1'b0;
    end else begin
      if (key_wr_i && key_wdata_i == `PFS_KEY1) begin
        key1_ff <= 1'b1;
        unlk_ff <= 1'b0;
      end else if (key_wr_i && key1_ff && key_wdata_i == `PFS_KEY2) begin
        key1_ff <= 1'b0;
        unlk_ff <= 1'b1;
      end else if (any_wr) begin
        key1_ff <= 1'b0;
        unlk_ff <= 1'b0;
      end
      unlocked_o <= unlk_ff;
    end
  end

  // --------------------------------------------------------------
  // page and target capture
  // --------------------------------------------------------------
  // frozen while busy so a stray table write cannot move the target
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      page_ff <= 8'h00;
      tgt_ff  <= {AW{1'b0}};
    end else if (state_ff == ST_IDLE) begin
      if (page_wr_i) begin
        page_ff <= page_wdata_i;
      end
      if (tbl_wr_i) begin
        // low row and word bits are dropped later for erase use
        tgt_ff <= {page_ff, tbl_addr_i};
      end
    end
  end

  // --------------------------------------------------------------
  // control and sequencing
  // --------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_ff    <= ST_IDLE;
      ctrl_ff     <= `PFS_CTRL_RST;
      cnt_ff      <= {CW{1'b0}};
      idx_ff      <= {(`PFS_ROW_BITS+1){1'b0}};
      ctrl_o      <= `PFS_CTRL_RST;
      cpu_stall_o <= 1'b0;
      fl_erase_o  <= 1'b0;
      fl_prog_o   <= 1'b0;
      fl_addr_o   <= {AW{1'b0}};
      fl_data_o   <= {DW{1'b0}};
    end else begin
      fl_erase_o <= 1'b0;
      fl_prog_o  <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (ctrl_wr_i) begin
            // start bit only sticks when accepted
            ctrl_ff <= {go_w & (ers_w | prg_w), ctrl_wdata_i[14:0]};
          end
          if (go_w && ers_w) begin
            state_ff    <= ST_ERASE;
            cpu_stall_o <= 1'b1;
            cnt_ff      <= ERASE_CYC[CW-1:0];
            fl_erase_o  <= 1'b1;
            fl_addr_o   <= tgt_ff & ~{{(AW-`PFS_PAGE_BITS){1'b0}},
                           {`PFS_PAGE_BITS{1'b1}}};
          end else if (go_w && prg_w) begin
            state_ff    <= ST_PROG;
            cpu_stall_o <= 1'b1;
            cnt_ff      <= PROG_CYC[CW-1:0];
            idx_ff      <= {(`PFS_ROW_BITS+1){1'b0}};
          end
        end
        ST_ERASE: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (last_cyc(cnt_ff)) begin
            state_ff               <= ST_IDLE;
            cpu_stall_o            <= 1'b0;
            ctrl_ff[`PFS_START_BIT] <= 1'b0;
          end
        end
        ST_PROG: begin
          // one row: each buffer word pulsed once to the array, then
          // wait; PROG_CYC must leave room for all 64 words
          if (!idx_ff[`PFS_ROW_BITS]) begin
            fl_prog_o <= 1'b1;
            fl_addr_o <= {tgt_ff[AW-1:`PFS_ROW_BITS], word_w};
            fl_data_o <= rowbuf[word_w];
            idx_ff    <= idx_ff + 1'b1;
          end
          cnt_ff <= cnt_ff - 1'b1;
          if (last_cyc(cnt_ff)) begin
            state_ff               <= ST_IDLE;
            cpu_stall_o            <= 1'b0;
            fl_prog_o              <= 1'b0;
            ctrl_ff[`PFS_START_BIT] <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      ctrl_o <= ctrl_ff;
    end
  end
endmodule // pfs_sequencer

// ---- tb/pfs_sequencer_assertions.sv ----
// port checker for the flash erase/program sequencer
// bound to pfs_sequencer from the bench; single clock domain
module pfs_sequencer_assertions #(
  parameter ERASE_CYC = 16,
  parameter PROG_CYC  = 80
) (
  // clock, reset and writes
  input wire        clk_sys_i,
  input wire        nrst_i,
  input wire        ctrl_wr_i,
  input wire [15:0] ctrl_wdata_i,
  input wire        key_wr_i,
  input wire [7:0]  key_wdata_i,
  input wire        page_wr_i,
  input wire        tbl_wr_i,
  // status and flash side
  input wire [15:0] ctrl_o,
  input wire        cpu_stall_o,
  input wire        unlocked_o,
  input wire        fl_erase_o,
  input wire [23:0] fl_addr_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // stall length counter; ers_ff remembers an erase is running
  reg [11:0] cnt_ff;
  reg        ers_ff;
  always @(posedge clk_sys_i) begin
    cnt_ff <= (!nrst_i || !cpu_stall_o) ? 12'h000 : cnt_ff + 12'h001;
    ers_ff <= nrst_i && (fl_erase_o || (ers_ff && cpu_stall_o));
  end
  wire go  = ctrl_wr_i && ctrl_wdata_i[15] && ctrl_wdata_i[14];
  wire ers = go && ctrl_wdata_i[6] && ctrl_wdata_i[3:0] == 4'h2;
  wire prg = go && !ctrl_wdata_i[6] && ctrl_wdata_i[3:0] == 4'h1;
  sequence unl;
    key_wr_i && key_wdata_i == 8'h55 ##1 key_wr_i && key_wdata_i == 8'haa;
  endsequence
  a_erase_start: assert property (
    unl ##1 ers |=> cpu_stall_o && fl_erase_o && fl_addr_o[8:0] == 9'h000)
    else $error("erase did not start");
  a_prog_start: assert property (
    unl ##1 prg |=> cpu_stall_o && !fl_erase_o) else $error("no program");
  a_bad_op: assert property (
    unl ##1 go && !ers && !prg |=> !cpu_stall_o) else $error("bad op ran");
  a_stall_len: assert property (
    $fell(cpu_stall_o) |-> cnt_ff == (ers_ff ? ERASE_CYC : PROG_CYC))
    else $error("stall length wrong");
  a_start_clears: assert property (
    $fell(cpu_stall_o) |-> ##[0:1] !ctrl_o[15]) else $error("start stuck");
  a_locked_refuse: assert property (
    ctrl_wr_i && !unlocked_o && !$past(key_wr_i) && !cpu_stall_o
    |=> !cpu_stall_o && !fl_erase_o) else $error("locked start ran");
  a_flash_write_enable_bit_ignored: assert property (
    ctrl_wr_i && !ctrl_wdata_i[14] && !cpu_stall_o |=> !cpu_stall_o)
    else $error("start without write enable ran");
  a_key_broken: assert property (
    key_wr_i && key_wdata_i == 8'h55 ##1 page_wr_i || tbl_wr_i ##1 key_wr_i
    |=> ##1 !unlocked_o) else $error("split keys unlocked");
  a_key_accept: assert property (
    unl |=> ##1 unlocked_o) else $error("unlock not shown");
  cover property (unl ##1 ers);
  cover property (unl ##1 prg);
  cover property ($fell(cpu_stall_o));
endmodule // pfs_sequencer_assertions

// ---- tb/pfs_sequencer_test.sv ----
// self-checking bench for the flash sequencer
// drives ports directly; short counts keep the run brief
module pfs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam EC = 16, PC = 80;
  logic clk_sys_i = 0, nrst_i = 0;
  logic [3:0] st = 0;
  logic [23:0] dat = 0, ea, e[64];
  logic [15:0] adr = 0, ctrl_o;
  logic stl, unl, fe, fp;
  logic [23:0] fa, fd, q[$];
  int err_count = 0, compares = 0, cyc = 0, n, pg, a;
  pfs_sequencer #(.ERASE_CYC(EC), .PROG_CYC(PC)) u_pfs_sequencer (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ctrl_wr_i(st[3]),
    .ctrl_wdata_i(dat[15:0]), .key_wr_i(st[2]), .key_wdata_i(dat[7:0]),
    .page_wr_i(st[1]), .page_wdata_i(dat[7:0]), .tbl_wr_i(st[0]),
    .tbl_addr_i(adr), .tbl_data_i(dat), .ctrl_o(ctrl_o),
    .cpu_stall_o(stl), .unlocked_o(unl), .fl_erase_o(fe),
    .fl_prog_o(fp), .fl_addr_o(fa), .fl_data_o(fd));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (fp) q.push_back(fd);
    if (fe) ea = fa;
    if (cyc > 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // k: 0 control, 1 key, 2 page, 3 table, 4 idle
  task automatic w(input int k, input int d, input int ad = 0);
    st = (k < 4) ? 4'h8 >> k : 4'h0;
    dat = d[23:0];
    adr = ad[15:0];
    @(posedge clk_sys_i) #1;
  endtask
  task automatic chk(input string s, input logic [23:0] x, y);
    compares++;
    if (y !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, x, y);
    end
  endtask
  // md: 0 full unlock, 1 none, 2 keys split by a page write
  task automatic op(input int cmd, input int md, input int el);
    if (md != 1) w(1, 'h55);
    if (md == 2) w(2, pg);
    if (md != 1) w(1, 'haa);
    w(0, cmd);
    n = 0;
    for (int i = 0; i < 3000 && (i < 3 || stl); i++) begin
      n += (stl === 1'b1);
      w(4, 0);
    end
    w(4, 0);
    chk("stall cycles", el, n);
    chk("control", cmd & 'h7fff, ctrl_o);
  endtask
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(65));
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    chk("reset control", 0, ctrl_o);
    pg = $urandom_range(255);
    a = $urandom_range(16'hffff);
    w(2, pg);
    w(3, 0, a);
    op('hc042, 0, EC);
    chk("erase address", ((pg << 16) | a) & 'hfffe00, ea);
    for (int i = 0; i < 64; i++) begin
      e[i] = $urandom;
      w(3, e[i], i);
    end
    q.delete();
    op('hc001, 0, PC);
    chk("row words", 64, q.size());
    foreach (e[i]) chk("row word", e[i], q[i]);
    op('hc042, 1, 0);
    op('h8042, 0, 0);
    op('hc003, 0, 0);
    op('hc042, 2, 0);
    give_verdict();
  end
endmodule // pfs_sequencer_test
bind pfs_sequencer pfs_sequencer_assertions #(
  .ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_chk (
  .clk_sys_i, .nrst_i, .ctrl_wr_i, .ctrl_wdata_i, .key_wr_i, .key_wdata_i,
  .page_wr_i, .tbl_wr_i, .ctrl_o, .cpu_stall_o, .unlocked_o, .fl_erase_o,
  .fl_addr_o);
